// ===== rtl/mapc_pkg.sv
/*
  Package for the max-address protection command block: opcodes, feature codes,
  register bit positions, protection states and the command/answer carriers.
  Assumes a taskfile front end that delivers one decoded command per pulse.
*/
package mapc_pkg;

  // Opcodes and feature codes
  localparam logic [7:0] MAPC_OP_SETMAX    = 8'hf9;
  localparam logic [7:0] MAPC_OP_SETMAX48  = 8'h37;
  localparam logic [7:0] MAPC_OP_RNATIVE   = 8'hf8;
  localparam logic [7:0] MAPC_OP_RNATIVE48 = 8'h27;
  localparam logic [7:0] MAPC_FEAT_SETPW   = 8'h01;
  localparam logic [7:0] MAPC_FEAT_LOCK    = 8'h02;
  localparam logic [7:0] MAPC_FEAT_UNLOCK  = 8'h03;
  localparam logic [7:0] MAPC_FEAT_FREEZE  = 8'h04;

  // Error and status register bit positions
  localparam int MAPC_ERR_ABT_BIT = 2;
  localparam int MAPC_STS_ERR_BIT = 0;
  localparam int MAPC_STS_RDY_BIT = 6;
  localparam int MAPC_STS_DSC_BIT = 4;

  // Persistence bit in sector count current
  localparam int MAPC_NV_BIT = 0;

  // Largest address that still fits the 28-bit identify words
  localparam logic [47:0] MAPC_LBA28_MAX = 48'h000_00fff_ffff;

  // Reset values
  localparam logic [7:0] MAPC_ERR_RST = 8'h00;
  localparam logic [7:0] MAPC_STS_RST = 8'h50;

  // Protection states
  typedef enum logic [1:0] {
    MAPC_UNLOCKED,
    MAPC_LOCKED,
    MAPC_FROZEN
  } mapc_prot_e;

  // Command as written by the host into the taskfile
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  feature;
    logic [7:0]  count_cur;
    logic [47:0] lba;
  } mapc_cmd_s;

  // Identify word update towards the identify store
  typedef struct packed {
    logic        upd48;
    logic        upd28;
    logic [47:0] value;
  } mapc_ident_s;

endpackage : mapc_pkg

// ===== rtl/mapc_hob_mux.sv
/*
  Returns the stored maximum address in the three address registers,
  choosing the low or high three bytes by the high-order-byte select.
  Assumes the select comes from logic on the same clock.
*/
`timescale 1ns/1ps
module mapc_hob_mux import mapc_pkg::*; (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Source
  input  wire logic [47:0] max_lba,
  input  wire logic        hob,
  // Address registers
  output logic      [7:0]  sect_num_ff,
  output logic      [7:0]  cyl_low_ff,
  output logic      [7:0]  cyl_high_ff
);

  logic [7:0] nxt_sect_num;
  logic [7:0] nxt_cyl_low;
  logic [7:0] nxt_cyl_high;

  // Byte select by high-order-byte flag
  always_comb begin
    if (hob) begin
      nxt_sect_num = max_lba[31:24];
      nxt_cyl_low  = max_lba[39:32];
      nxt_cyl_high = max_lba[47:40];
    end else begin
      nxt_sect_num = max_lba[7:0];
      nxt_cyl_low  = max_lba[15:8];
      nxt_cyl_high = max_lba[23:16];
    end
  end

  // Register the returned bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      sect_num_ff  <= 8'h00;
      cyl_low_ff   <= 8'h00;
      cyl_high_ff  <= 8'h00;
    end else begin
      sect_num_ff  <= nxt_sect_num;
      cyl_low_ff   <= nxt_cyl_low;
      cyl_high_ff  <= nxt_cyl_high;
    end
  end

endmodule : mapc_hob_mux

// ===== rtl/mapc_top.sv
/*
  Command interpreter for the host-protected-area limit: freeze-lock and the
  48-bit set-max-address command, with access checking against the limit.
  Assumes commands arrive as one-cycle pulses from same-clock taskfile logic,
  and that the nonvolatile store and identify data sit outside.
*/
// What this block does
// - Feature 04h with opcode F9h, unless right after 28-bit read-native-max, decodes as the freeze-lock request.
// - F9h right after 28-bit read-native-max is the plain 28-bit set-max.
// - After freeze-lock, enter frozen and abort all later set-max commands.
// - Opcode 37h set-max must directly follow 48-bit read-native-max.
// - Accepted 48-bit set-max replaces the limit; accesses beyond it abort.
// - Above 268,435,455 update words 103:100 only; else both groups.
// - Abort 48-bit set-max if unsupported, too big, 28-bit set, unpaired, locked/frozen.
// - A second nonvolatile 48-bit set-max aborts until power-on or hard reset.
// - Sector count bit 0 set makes the new limit survive power-on.
// - Nonvolatile option is invalid while in address offset mode.
// - Requested limit is taken whole from the 48-bit address delivered with the command.
// - Completion returns the limit, low or high bytes by high-order select.
// - In locked state accept only unlock and freeze-lock subcommands.
`timescale 1ns/1ps
module mapc_top import mapc_pkg::*; #(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_e8e0_88af,
  parameter bit          SUPPORTED  = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Command from taskfile
  input  wire logic        cmd_valid,
  input  wire mapc_cmd_s   cmd,
  input  wire logic        hob,
  input  wire logic        offset_mode,
  // Access check
  input  wire logic        acc_valid,
  input  wire logic [47:0] acc_lba,
  output logic             acc_abort,
  // Nonvolatile limit restored at power-on
  input  wire logic        nv_valid,
  input  wire logic [47:0] nv_max,
  output logic             nv_write_ff,
  output logic      [47:0] nv_data_ff,
  // Completion
  output logic             done_ff,
  output logic             set28_ff,
  output logic             lock_req_ff,
  output logic             unlock_req_ff,
  output logic             setpw_req_ff,
  output logic      [7:0]  command_error_flags,
  output logic      [7:0]  device_status_flags,
  output mapc_ident_s      ident_ff,
  output logic      [7:0]  sect_num_ff,
  output logic      [7:0]  cyl_low_ff,
  output logic      [7:0]  cyl_high_ff,
  output logic      [1:0]  prot_state
);

  // Protection state, limit and command history
  mapc_prot_e  prot_ff, nxt_prot;
  logic [47:0] max_ff, nxt_max;
  logic [7:0]  prev_op_ff, nxt_prev_op;
  logic        nv_used_ff, nxt_nv_used;
  logic        hpa28_ff, nxt_hpa28;

  // Next values of the completion pulses and the nonvolatile store
  logic        done_nx, set28_nx, lock_nx, unlock_nx, setpw_nx, nvw_nx;
  logic [47:0] nvd_nx;

  // Error and status registers and identify update
  logic [7:0]  err_ff, nxt_err, sts_ff, nxt_sts;
  mapc_ident_s ident_nx;

  // Decode helpers
  logic        is_f9, after_rn28, after_rn48, bad48, abort;

  // Opcode and command history decode
  assign is_f9      = cmd.opcode == MAPC_OP_SETMAX;
  assign after_rn28 = prev_op_ff == MAPC_OP_RNATIVE;
  assign after_rn48 = prev_op_ff == MAPC_OP_RNATIVE48;

  // Conditions that abort the 48-bit set-max
  assign bad48 = !SUPPORTED || (cmd.lba > NATIVE_MAX) || hpa28_ff || !after_rn48
                 || (prot_ff != MAPC_UNLOCKED)
                 || (cmd.count_cur[MAPC_NV_BIT] && (nv_used_ff || offset_mode));

  // Command decode and protection state
  always_comb begin
    nxt_prot    = prot_ff;
    nxt_max     = max_ff;
    nxt_nv_used = nv_used_ff;
    nxt_hpa28   = hpa28_ff;
    nxt_prev_op = prev_op_ff;
    done_nx     = 1'b0;
    set28_nx    = 1'b0;
    lock_nx     = 1'b0;
    unlock_nx   = 1'b0;
    setpw_nx    = 1'b0;
    nvw_nx      = 1'b0;
    nvd_nx      = nv_data_ff;
    abort       = 1'b0;
    // Identify data shows the current limit while no update is pending
    ident_nx    = '0;
    ident_nx.value = max_ff;
    // Power-on restore of a nonvolatile limit
    if (nv_valid) begin
      nxt_max = nv_max;
    end
    // One command per pulse; every command completes one cycle later
    if (cmd_valid) begin
      done_nx     = 1'b1;
      nxt_prev_op = cmd.opcode;
      if (is_f9 && after_rn28) begin
        // A locked or frozen device refuses the plain set-max as well
        if (prot_ff != MAPC_UNLOCKED) begin
          abort = 1'b1;
        end else begin
          set28_nx  = 1'b1;
          nxt_hpa28 = 1'b1;
        end
      end else if (is_f9) begin
        if (prot_ff == MAPC_FROZEN) begin
          abort = 1'b1;
        end else if (cmd.feature == MAPC_FEAT_FREEZE) begin
          nxt_prot = MAPC_FROZEN;
        end else if (cmd.feature == MAPC_FEAT_UNLOCK) begin
          unlock_nx = 1'b1;
        end else if (prot_ff == MAPC_LOCKED) begin
          abort = 1'b1;
        end else if (cmd.feature == MAPC_FEAT_LOCK) begin
          lock_nx  = 1'b1;
          nxt_prot = MAPC_LOCKED;
        end else if (cmd.feature == MAPC_FEAT_SETPW) begin
          setpw_nx = 1'b1;
        end else begin
          abort = 1'b1;
        end
      end else if (cmd.opcode == MAPC_OP_SETMAX48) begin
        // Extended set-max: refuse first, then limit, identify data and store
        if (bad48) begin
          abort = 1'b1;
        end else begin
          nxt_max        = cmd.lba;
          ident_nx.value = cmd.lba;
          ident_nx.upd48 = 1'b1;
          ident_nx.upd28 = cmd.lba <= MAPC_LBA28_MAX;
          if (cmd.count_cur[MAPC_NV_BIT]) begin
            nvw_nx      = 1'b1;
            nvd_nx      = cmd.lba;
            nxt_nv_used = 1'b1;
          end
        end
      end
    end
    // Abort sets ABT and ERR, busy and fault stay clear
    nxt_err = MAPC_ERR_RST;
    nxt_sts = MAPC_STS_RST;
    if (done_nx) begin
      nxt_err[MAPC_ERR_ABT_BIT] = abort;
      nxt_sts[MAPC_STS_ERR_BIT] = abort;
    end else begin
      nxt_err = err_ff;
      nxt_sts = sts_ff;
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      prot_ff       <= MAPC_UNLOCKED;
      max_ff        <= NATIVE_MAX;
      prev_op_ff    <= 8'h00;
      nv_used_ff    <= 1'b0;
      hpa28_ff      <= 1'b0;
      done_ff       <= 1'b0;
      set28_ff      <= 1'b0;
      lock_req_ff   <= 1'b0;
      unlock_req_ff <= 1'b0;
      setpw_req_ff  <= 1'b0;
      nv_write_ff   <= 1'b0;
      nv_data_ff    <= 48'h0;
      err_ff        <= MAPC_ERR_RST;
      sts_ff        <= MAPC_STS_RST;
      ident_ff      <= '0;
    end else begin
      prot_ff       <= nxt_prot;
      max_ff        <= nxt_max;
      prev_op_ff    <= nxt_prev_op;
      nv_used_ff    <= nxt_nv_used;
      hpa28_ff      <= nxt_hpa28;
      done_ff       <= done_nx;
      set28_ff      <= set28_nx;
      lock_req_ff   <= lock_nx;
      unlock_req_ff <= unlock_nx;
      setpw_req_ff  <= setpw_nx;
      nv_write_ff   <= nvw_nx;
      nv_data_ff    <= nvd_nx;
      err_ff        <= nxt_err;
      sts_ff        <= nxt_sts;
      ident_ff      <= ident_nx;
    end
  end

  // Accesses beyond the limit abort
  assign acc_abort = acc_valid && (acc_lba > max_ff);

  // Register views on the ports
  assign command_error_flags = err_ff;
  assign device_status_flags = sts_ff;
  assign prot_state          = prot_ff;

  // Limit returned through the address registers
  mapc_hob_mux u_hob (
    .mclk        (mclk),
    .srst        (srst),
    .max_lba     (max_ff),
    .hob         (hob),
    .sect_num_ff (sect_num_ff),
    .cyl_low_ff  (cyl_low_ff),
    .cyl_high_ff (cyl_high_ff)
  );

endmodule : mapc_top

// ===== dv/mapc_top_assertions.sv
/* Port checker for mapc_top.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
module mapc_top_assertions import mapc_pkg::*; (
  // Clock, reset and command
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire mapc_cmd_s   cmd,
  // Answers
  input wire logic        acc_valid,
  input wire logic [47:0] acc_lba,
  input wire logic        acc_abort,
  input wire logic        done_ff,
  input wire logic        set28_ff,
  input wire logic        lock_req_ff,
  input wire logic        unlock_req_ff,
  input wire logic        setpw_req_ff,
  input wire logic        nv_write_ff,
  input wire logic [47:0] nv_data_ff,
  input wire logic [7:0]  command_error_flags,
  input wire logic [7:0]  device_status_flags,
  input wire mapc_ident_s ident_ff,
  input wire logic [1:0]  prot_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [7:0]  last_op_ff, nxt_last_op;
  logic [47:0] lim_ff, nxt_lim;
  logic        seen_ff, nxt_seen;
  logic        f9;
  // Previous opcode and last reported limit
  always_comb begin
    f9 = cmd_valid && cmd.opcode == MAPC_OP_SETMAX;
    nxt_last_op = cmd_valid ? cmd.opcode : last_op_ff;
    nxt_lim = ident_ff.upd48 ? ident_ff.value : lim_ff;
    nxt_seen = seen_ff | ident_ff.upd48;
  end
  always_ff @(posedge mclk) begin
    last_op_ff <= srst ? 8'h00 : nxt_last_op;
    lim_ff <= nxt_lim;
    seen_ff <= srst ? 1'b0 : nxt_seen;
  end
  property p_freeze;
    f9 && cmd.feature == MAPC_FEAT_FREEZE && last_op_ff != MAPC_OP_RNATIVE && prot_state != MAPC_FROZEN
      |=> prot_state == MAPC_FROZEN && !command_error_flags[2];
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not taken");
  property p_set28;
    f9 && last_op_ff == MAPC_OP_RNATIVE && prot_state == MAPC_UNLOCKED |=> set28_ff && done_ff;
  endproperty
  a_set28: assert property (p_set28) else $error("plain set-max not decoded");
  property p_frozen;
    f9 && prot_state == MAPC_FROZEN
      |=> command_error_flags[2] && !set28_ff && !lock_req_ff && !unlock_req_ff && !setpw_req_ff;
  endproperty
  a_frozen: assert property (p_frozen) else $error("command passed while frozen");
  property p_stay; prot_state == MAPC_FROZEN |=> prot_state == MAPC_FROZEN; endproperty
  a_stay: assert property (p_stay) else $error("frozen state left");
  property p_unpaired;
    cmd_valid && cmd.opcode == MAPC_OP_SETMAX48 && last_op_ff != MAPC_OP_RNATIVE48
      |=> command_error_flags[2] && !ident_ff.upd48;
  endproperty
  a_unpaired: assert property (p_unpaired) else $error("unpaired set-max taken");
  property p_ident; ident_ff.upd48 |-> done_ff && ident_ff.upd28 == (ident_ff.value <= MAPC_LBA28_MAX); endproperty
  a_ident: assert property (p_ident) else $error("identify update wrong");
  property p_limit;
    acc_valid && (seen_ff || ident_ff.upd48)
      |-> acc_abort == (acc_lba > (ident_ff.upd48 ? ident_ff.value : lim_ff));
  endproperty
  a_limit: assert property (p_limit) else $error("access check wrong");
  property p_flags;
    done_ff && command_error_flags[2] |-> device_status_flags[0] && device_status_flags[7:5] == 3'b010;
  endproperty
  a_flags: assert property (p_flags) else $error("abort status wrong");
  property p_locked;
    f9 && prot_state == MAPC_LOCKED && cmd.feature != MAPC_FEAT_UNLOCK && cmd.feature != MAPC_FEAT_FREEZE
      |=> command_error_flags[2] && !set28_ff && !lock_req_ff && !setpw_req_ff;
  endproperty
  a_locked: assert property (p_locked) else $error("command passed while locked");
  property p_unlock;
    f9 && cmd.feature == MAPC_FEAT_UNLOCK && last_op_ff != MAPC_OP_RNATIVE && prot_state == MAPC_LOCKED
      |=> unlock_req_ff && !command_error_flags[2];
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock refused while locked");
  property p_lockreq;
    f9 && cmd.feature == MAPC_FEAT_LOCK && last_op_ff != MAPC_OP_RNATIVE && prot_state == MAPC_UNLOCKED
      |=> lock_req_ff && prot_state == MAPC_LOCKED;
  endproperty
  a_lockreq: assert property (p_lockreq) else $error("lock not taken");
  property p_nvwrite;
    cmd_valid && cmd.opcode == MAPC_OP_SETMAX48 && cmd.count_cur[MAPC_NV_BIT]
      |=> nv_write_ff == ident_ff.upd48 && (!nv_write_ff || nv_data_ff == ident_ff.value);
  endproperty
  a_nvwrite: assert property (p_nvwrite) else $error("nonvolatile store wrong");
  property p_nvvol;
    cmd_valid && cmd.opcode == MAPC_OP_SETMAX48 && !cmd.count_cur[MAPC_NV_BIT] |=> !nv_write_ff;
  endproperty
  a_nvvol: assert property (p_nvvol) else $error("volatile limit stored");
endmodule : mapc_top_assertions

// ===== dv/mapc_host_model.sv
/* Host model issuing taskfile commands.
   Assumes the bench calls its tasks on the shared mclk. */
`timescale 1ns/1ps
module mapc_host_model import mapc_pkg::*; (
  // Clock
  input wire logic mclk,
  // Command towards the device
  output logic      cmd_valid,
  output mapc_cmd_s cmd
);
  // Idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One command held for its taking edge, then scrambled
  task send(input logic [7:0] op, ft, cnt, input logic [47:0] lba);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, ft, cnt, lba};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
  endtask : send
  // Extended set-max always right after its read-native partner
  task set48(input logic [47:0] lba, input logic nv);
    send(MAPC_OP_RNATIVE48, 8'h00, 8'h00, 48'h0);
    send(MAPC_OP_SETMAX48, 8'h00, {7'h00, nv}, lba);
  endtask : set48
endmodule : mapc_host_model

// ===== dv/mapc_top_tb.sv
/* Self-checking bench for mapc_top with host model and checker.
   Assumes 40 MHz mclk and synchronous active-high srst. */
`timescale 1ns/1ps
module mapc_top_tb import mapc_pkg::*;;
  localparam logic [47:0] NMAX = 48'h0000_e8e0_88af;
  logic        mclk, srst, hob, offset_mode, acc_valid, cmd_valid, done_ff, set28_ff, acc_abort, nv_write_ff, e;
  logic        nv_valid;
  logic [47:0] acc_lba, nv_data_ff, v, nv_max;
  logic [7:0]  command_error_flags, device_status_flags, sect_num_ff, cyl_low_ff, cyl_high_ff;
  logic [1:0]  prot_state;
  logic [31:0] rnd;
  mapc_cmd_s   cmd;
  mapc_ident_s ident_ff;
  int          mismatches, num_checks;
  logic        q[$];
  mapc_top #(.NATIVE_MAX(NMAX), .SUPPORTED(1'b1)) i_mapc_top(.mclk, .srst, .cmd_valid, .cmd, .hob, .offset_mode,
    .acc_valid, .acc_lba, .acc_abort, .nv_valid, .nv_max, .nv_write_ff, .nv_data_ff, .done_ff,
    .set28_ff, .lock_req_ff(), .unlock_req_ff(), .setpw_req_ff(), .command_error_flags, .device_status_flags,
    .ident_ff, .sect_num_ff, .cyl_low_ff, .cyl_high_ff, .prot_state);
  mapc_host_model i_mapc_host_model(.mclk, .cmd_valid, .cmd);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task chk(input logic [47:0] s, x);
    num_checks++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk
  task c(input logic [7:0] op, ft, input logic ab);
    q.push_back(ab);
    i_mapc_host_model.send(op, ft, 8'h00, 48'h0);
  endtask : c
  task s48(input logic [47:0] l, input logic nv, ab);
    q.push_back(1'b0);
    q.push_back(ab);
    i_mapc_host_model.set48(l, nv);
  endtask : s48
  task acc(input logic [47:0] l, input logic x);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_lba <= l;
    @(negedge mclk);
    chk(acc_abort, x);
  endtask : acc
  task rd(input logic [47:0] l);
    for (int h = 0; h < 2; h++) begin
      @(posedge mclk);
      hob <= h[0];
      repeat (2) @(posedge mclk);
      #1 chk({cyl_high_ff, cyl_low_ff, sect_num_ff}, h ? l[47:24] : l[23:0]);
    end
  endtask : rd
  task rst;
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
  endtask : rst
  task complete_run;
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Result monitor: oldest expectation against each completion
  always @(negedge mclk) begin
    if (done_ff === 1'b1) begin
      e = q.size() ? q.pop_front() : 1'bx;
      chk(command_error_flags, {5'h00, e, 2'h0});
      chk(device_status_flags, {7'h28, e});
    end
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    complete_run;
  end
  // Main sequence
  initial begin
    {hob, offset_mode, acc_valid, mismatches, num_checks} = '0;
    acc_lba = 48'h0;
    nv_valid = 1'b0;
    nv_max = 48'h0;
    rnd = 32'hbda26bd4;
    srst = 1'b1;
    rst;
    chk({prot_state, command_error_flags, device_status_flags}, 18'h00050);
    c(MAPC_OP_SETMAX48, 8'h00, 1'b1);
    repeat (3) begin
      rnd = lfsr(rnd);
      v = {20'h0, rnd[27:0]};
      s48(v, 1'b0, 1'b0);
      rd(v);
      acc(v, 1'b0);
      acc(v + 48'h1, 1'b1);
    end
    s48(NMAX + 48'h1, 1'b0, 1'b1);
    offset_mode <= 1'b1;
    s48(48'h0000_1000_0000, 1'b1, 1'b1);
    offset_mode <= 1'b0;
    s48(48'h0000_1000_0000, 1'b1, 1'b0);
    @(negedge mclk);
    chk(nv_data_ff, 48'h0000_1000_0000);
    s48(48'h0000_2000_0000, 1'b1, 1'b1);
    c(MAPC_OP_SETMAX, MAPC_FEAT_FREEZE, 1'b0);
    c(MAPC_OP_SETMAX, MAPC_FEAT_LOCK, 1'b1);
    s48(48'h100, 1'b0, 1'b1);
    c(MAPC_OP_SETMAX, MAPC_FEAT_UNLOCK, 1'b1);
    c(MAPC_OP_RNATIVE, 8'h00, 1'b0);
    c(MAPC_OP_SETMAX, 8'h00, 1'b1);
    chk(prot_state, MAPC_FROZEN);
    rst;
    // Power-on restore of the stored limit
    @(posedge mclk);
    nv_valid <= 1'b1;
    nv_max <= 48'h0000_1000_0000;
    @(posedge mclk);
    nv_valid <= 1'b0;
    acc(48'h0000_1000_0000, 1'b0);
    acc(48'h0000_1000_0001, 1'b1);
    c(MAPC_OP_RNATIVE, 8'h00, 1'b0);
    c(MAPC_OP_SETMAX, 8'h00, 1'b0);
    s48(48'h100, 1'b0, 1'b1);
    c(MAPC_OP_SETMAX, 8'h05, 1'b1);
    c(MAPC_OP_SETMAX, MAPC_FEAT_SETPW, 1'b0);
    rst;
    c(MAPC_OP_SETMAX, MAPC_FEAT_LOCK, 1'b0);
    c(MAPC_OP_SETMAX, MAPC_FEAT_SETPW, 1'b1);
    s48(48'h100, 1'b0, 1'b1);
    c(MAPC_OP_SETMAX, MAPC_FEAT_UNLOCK, 1'b0);
    c(MAPC_OP_SETMAX, MAPC_FEAT_FREEZE, 1'b0);
    repeat (3) @(posedge mclk);
    chk(q.size(), 0);
    complete_run;
  end
endmodule : mapc_top_tb
bind mapc_top mapc_top_assertions i_mapc_top_assertions(.mclk, .srst, .cmd_valid, .cmd, .acc_valid, .acc_lba,
  .acc_abort, .done_ff, .set28_ff, .lock_req_ff, .unlock_req_ff, .setpw_req_ff, .nv_write_ff, .nv_data_ff,
  .command_error_flags, .device_status_flags, .ident_ff, .prot_state);
